/* File: lpwr_regs.svh */
// Register offsets, field positions, reset values and counts of the power/wake controller
`ifndef LPWR_REGS_SVH
`define LPWR_REGS_SVH

// ============================================================
// Register byte offsets
`define OFS_PWR_CTRL      8'h00
`define OFS_PWR_STAT      8'h04
`define OFS_EDGE_RISE     8'h08
`define OFS_EDGE_FALL     8'h0C
`define OFS_EDGE_MASK     8'h10
`define OFS_EDGE_PEND     8'h14
`define OFS_MON_CTRL      8'h18

// ============================================================
// Power control fields
`define CTRL_MODE_LSB     0
`define CTRL_DEEP_LP_BIT  2

// ============================================================
// Supply monitor control fields
`define MON_EN_BIT        0
`define MON_FALL_BIT      1
`define MON_RISE_BIT      2

// ============================================================
// Reset values and sizes
`define EDGE_LINES        19
`define PIN_LINES         16
`define LINE_MON          16
`define LINE_RTC          17
`define LINE_USB          18
`define RESET_WORD        32'h0000_0000

`endif

/* File: lpwr_pkg.sv */
// Types shared by the power-mode and wake controller
package lpwr_pkg;

  // ============================================================
  // Power modes and regulator modes
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP  = 2'b11,
    MODE_STBY  = 2'b10
  } pwr_mode_e;

  typedef enum logic [1:0] {
    REG_NORMAL = 2'b00,
    REG_LOWPWR = 2'b01,
    REG_OFF    = 2'b10
  } reg_mode_e;

  // ============================================================
  // Clock and power gating bundle
  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic pll_en;
    logic internal_fast_osc_en;
    logic external_fast_osc_en;
    logic core_domain_pwr;
    logic rtc_run;
    logic independent_watchdog_run;
  } gate_s;

endpackage : lpwr_pkg

/* File: lpwr_ctrl.sv */
// Low-power mode sequencer, supply monitor interrupt and edge interrupt unit
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "lpwr_regs.svh"

// Contract
// - Sleep stops only the core clock; peripherals keep running.
// - Any peripheral interrupt or event ends sleep.
// - Clock-stop disables PLL and both fast oscillators.
// - Clock-stop keeps core domain powered so state survives.
// - Clock-stop regulator is normal or low-power per software bit.
// - Clock-stop ends on any unmasked edge line, pins, monitor, RTC, USB.
// - Standby turns regulator off, powering down core, PLL and oscillators.
// - Standby loses core state; backup, RTC and standby logic keep it.
// - Standby ends on reset pin low, watchdog reset, wake rising, RTC alarm.
// - RTC and its clock never stop in clock-stop or standby.
// - Watchdog running in low power follows a nonvolatile setting.
// - Regulator starts in normal mode after every reset.
// - Normal in run/sleep/clock-stop, low-power only clock-stop, off only standby.
// - Device held in reset while supply is below low-voltage threshold.
// - Enabled monitor interrupts on falling, rising or both crossings.
// - Monitor stays inactive until software enables it.
// - Nineteen edge lines each raise an interrupt request.
// - Each line has rising/falling selection and its own mask.
// - Each line latches a trigger into a readable pending bit.
// - Sixteen lines come from general-purpose pins.
module lpwr_ctrl
  import lpwr_pkg::*;
#(
  parameter int LINES = `EDGE_LINES
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Core handshake
  input  wire logic              core_wfi_i,
  input  wire logic              periph_event_i,
  // Wake and reset sources (asynchronous)
  input  wire logic [15:0]       gpio_line_i,
  input  wire logic              supply_above_mon_i,
  input  wire logic              supply_above_lvr_i,
  input  wire logic              rtc_alarm_i,
  input  wire logic              usb_wake_i,
  input  wire logic              wake_pin_i,
  input  wire logic              external_reset_pin_n_i,
  input  wire logic              watchdog_reset_i,
  input  wire logic              wdt_lowpwr_run_cfg_i,
  // Power outputs
  output gate_s                  gate_o,
  output reg_mode_e              reg_mode_o,
  output pwr_mode_e              mode_o,
  output logic                   core_reset_o,
  output logic [LINES-1:0]       edge_irq_o,
  output logic                   supply_monitor_irq_o
);

  // ============================================================
  // Input synchronisers
  // Sixteen pins plus monitor, RTC, USB, low-voltage, wake, watchdog and reset pin
  localparam int NSYNC = 23;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] sync_d;

  always_ff @(posedge clk_i) begin
    sync_a <= {external_reset_pin_n_i, watchdog_reset_i, wake_pin_i, supply_above_lvr_i,
               usb_wake_i, rtc_alarm_i, supply_above_mon_i, gpio_line_i[15:1], gpio_line_i[0]};
    sync_b <= sync_a;
    sync_d <= sync_b;
  end

  logic [LINES-1:0] line_now;
  logic [LINES-1:0] line_old;
  logic             mon_now;
  logic             lvr_ok;
  logic             wake_rise;
  logic             rst_pin_low;
  logic             wdt_rst;
  logic             rtc_now;

  assign line_now    = sync_b[LINES-1:0];
  assign line_old    = sync_d[LINES-1:0];
  assign mon_now     = sync_b[`LINE_MON];
  assign rtc_now     = sync_b[`LINE_RTC];
  assign lvr_ok      = sync_b[19];
  assign wake_rise   = sync_b[20] & ~sync_d[20];
  assign wdt_rst     = sync_b[20+1];
  assign rst_pin_low = ~sync_b[NSYNC-1];

  // ============================================================
  // Registers
  logic [1:0]       mode_sel;
  logic             deep_lp;
  logic [LINES-1:0] rise_sel;
  logic [LINES-1:0] fall_sel;
  logic [LINES-1:0] line_mask;
  logic [LINES-1:0] pend;
  logic [2:0]       mon_ctrl;
  logic             mon_irq_flag;
  pwr_mode_e        state;

  logic wr;
  logic rd;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] wide(input logic [LINES-1:0] v);
    logic [31:0] r;
    r = '0;
    r[LINES-1:0] = v;
    return r;
  endfunction : wide

  logic [31:0] wdat_ctrl;
  logic [31:0] wdat_rise;
  logic [31:0] wdat_fall;
  logic [31:0] wdat_mask;
  logic [31:0] wdat_mon;
  logic [31:0] wdat_clr;
  assign wdat_ctrl = merge({29'h0, deep_lp, mode_sel}, wb_dat_i, wb_sel_i);
  assign wdat_rise = merge(wide(rise_sel), wb_dat_i, wb_sel_i);
  assign wdat_fall = merge(wide(fall_sel), wb_dat_i, wb_sel_i);
  assign wdat_mask = merge(wide(line_mask), wb_dat_i, wb_sel_i);
  assign wdat_mon  = merge({29'h0, mon_ctrl}, wb_dat_i, wb_sel_i);
  assign wdat_clr  = merge(`RESET_WORD, wb_dat_i, wb_sel_i);

  // Configuration clears on reset, on low supply and while in standby
  logic sys_rst;
  assign sys_rst = rst_i | ~lvr_ok;

  always_ff @(posedge clk_i) begin
    if (sys_rst || state == MODE_STBY) begin
      mode_sel <= 2'h0;
      deep_lp  <= 1'b0;
      rise_sel <= '0;
      fall_sel <= '0;
      line_mask <= '0;
      mon_ctrl <= 3'h0;
    end else if (wr) begin
      case (wb_adr_i)
        `OFS_PWR_CTRL: begin
          mode_sel <= wdat_ctrl[`CTRL_MODE_LSB +: 2];
          deep_lp  <= wdat_ctrl[`CTRL_DEEP_LP_BIT];
        end
        `OFS_EDGE_RISE: rise_sel  <= wdat_rise[LINES-1:0];
        `OFS_EDGE_FALL: fall_sel  <= wdat_fall[LINES-1:0];
        `OFS_EDGE_MASK: line_mask <= wdat_mask[LINES-1:0];
        `OFS_MON_CTRL:  mon_ctrl  <= wdat_mon[2:0];
        default: begin
        end
      endcase
    end
  end

  // ============================================================
  // Edge detection and pending bits
  logic [LINES-1:0] trig;
  logic [LINES-1:0] clr;
  logic [LINES-1:0] src_enable;
  always_comb begin
    src_enable = '1;
    src_enable[`LINE_MON] = mon_ctrl[`MON_EN_BIT];
  end
  assign trig = src_enable & ((rise_sel & line_now & ~line_old) |
                              (fall_sel & ~line_now & line_old));
  assign clr  = (wr && wb_adr_i == `OFS_EDGE_PEND) ? wdat_clr[LINES-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (sys_rst || state == MODE_STBY) begin
      pend <= '0;
    end else begin
      pend <= (pend & ~clr) | trig;
    end
  end

  // ============================================================
  // Supply monitor interrupt
  logic mon_rise;
  logic mon_fall;
  assign mon_rise = mon_now & ~sync_d[`LINE_MON];
  assign mon_fall = ~mon_now & sync_d[`LINE_MON];

  always_ff @(posedge clk_i) begin
    if (sys_rst || state == MODE_STBY || !mon_ctrl[`MON_EN_BIT]) begin
      mon_irq_flag <= 1'b0;
    end else if ((mon_ctrl[`MON_FALL_BIT] & mon_fall) | (mon_ctrl[`MON_RISE_BIT] & mon_rise)) begin
      mon_irq_flag <= 1'b1;
    end else if (wr && wb_adr_i == `OFS_MON_CTRL && wdat_mon[8]) begin
      mon_irq_flag <= 1'b0;
    end
  end

  // ============================================================
  // Mode sequencer
  logic any_wake;
  assign any_wake = |(pend & line_mask);

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      state <= MODE_RUN;
    end else begin
      case (state)
        MODE_RUN: begin
          if (core_wfi_i) begin
            case (mode_sel)
              2'd1:    state <= MODE_SLEEP;
              2'd2:    state <= MODE_DEEP;
              2'd3:    state <= MODE_STBY;
              default: state <= MODE_RUN;
            endcase
          end
        end
        MODE_SLEEP: if (periph_event_i || any_wake) state <= MODE_RUN;
        MODE_DEEP:  if (any_wake) state <= MODE_RUN;
        MODE_STBY: begin
          if (rst_pin_low || wdt_rst || wake_rise || rtc_now) begin
            state <= MODE_RUN;
          end
        end
        default: state <= MODE_RUN;
      endcase
    end
  end

  // ============================================================
  // Gating and regulator outputs
  gate_s     next_gate;
  reg_mode_e next_reg;
  always_comb begin
    next_gate = '{core_clk_en: 1'b1, periph_clk_en: 1'b1, pll_en: 1'b1,
                  internal_fast_osc_en: 1'b1, external_fast_osc_en: 1'b1,
                  core_domain_pwr: 1'b1, rtc_run: 1'b1, independent_watchdog_run: 1'b1};
    next_reg  = REG_NORMAL;
    case (state)
      MODE_SLEEP: next_gate.core_clk_en = 1'b0;
      MODE_DEEP: begin
        next_gate.core_clk_en          = 1'b0;
        next_gate.periph_clk_en        = 1'b0;
        next_gate.pll_en               = 1'b0;
        next_gate.internal_fast_osc_en = 1'b0;
        next_gate.external_fast_osc_en = 1'b0;
        next_gate.core_domain_pwr      = 1'b1;
        next_gate.independent_watchdog_run = wdt_lowpwr_run_cfg_i;
        next_reg = deep_lp ? REG_LOWPWR : REG_NORMAL;
      end
      MODE_STBY: begin
        next_gate.core_clk_en          = 1'b0;
        next_gate.periph_clk_en        = 1'b0;
        next_gate.pll_en               = 1'b0;
        next_gate.internal_fast_osc_en = 1'b0;
        next_gate.external_fast_osc_en = 1'b0;
        next_gate.core_domain_pwr      = 1'b0;
        next_gate.independent_watchdog_run = wdt_lowpwr_run_cfg_i;
        next_reg = REG_OFF;
      end
      default: begin
      end
    endcase
    next_gate.rtc_run = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      gate_o      <= '{default: 1'b1};
      reg_mode_o  <= REG_NORMAL;
      mode_o      <= MODE_RUN;
      core_reset_o <= 1'b1;
    end else begin
      gate_o      <= next_gate;
      reg_mode_o  <= next_reg;
      mode_o      <= state;
      core_reset_o <= (state == MODE_STBY);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      edge_irq_o           <= '0;
      supply_monitor_irq_o <= 1'b0;
    end else begin
      edge_irq_o           <= pend & line_mask;
      supply_monitor_irq_o <= mon_irq_flag;
    end
  end

  // ============================================================
  // Wishbone answer: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `RESET_WORD;
    end else begin
      wb_ack_o <= wr | rd;
      wb_dat_o <= `RESET_WORD;
      if (rd) begin
        case (wb_adr_i)
          `OFS_PWR_CTRL:  wb_dat_o <= {29'h0, deep_lp, mode_sel};
          `OFS_PWR_STAT:  wb_dat_o <= {27'h0, lvr_ok, mon_now, mon_irq_flag, state};
          `OFS_EDGE_RISE: wb_dat_o <= wide(rise_sel);
          `OFS_EDGE_FALL: wb_dat_o <= wide(fall_sel);
          `OFS_EDGE_MASK: wb_dat_o <= wide(line_mask);
          `OFS_EDGE_PEND: wb_dat_o <= wide(pend);
          `OFS_MON_CTRL:  wb_dat_o <= {23'h0, mon_irq_flag, 5'h0, mon_ctrl};
          default:        wb_dat_o <= `RESET_WORD;
        endcase
      end
    end
  end

endmodule : lpwr_ctrl

/* File: lpwr_monitor.sv */
// Port-level assertions for the power-mode and wake controller
`timescale 1ns/1ps
module lpwr_monitor
  import lpwr_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  // Watched signals
  input  wire logic      core_wfi_i,
  input  wire logic      supply_above_lvr_i,
  input  wire logic      wdt_lowpwr_run_cfg_i,
  input  wire gate_s     gate_o,
  input  wire reg_mode_e reg_mode_o,
  input  wire pwr_mode_e mode_o,
  input  wire logic      core_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ============================================================
  // Gating per mode; gating and mode_o are registered together from the state, so the settled cycle is extra margin
  a_sleep_core_only: assert property (
    mode_o == MODE_SLEEP && $past(mode_o) == MODE_SLEEP
    |-> !gate_o.core_clk_en && gate_o.periph_clk_en) else $error("Sleep gating wrong");
  a_stop_clocks_off: assert property (
    mode_o == MODE_DEEP && $past(mode_o) == MODE_DEEP |-> !gate_o.pll_en
    && !gate_o.internal_fast_osc_en && !gate_o.external_fast_osc_en && gate_o.core_domain_pwr)
    else $error("Clock-stop gating wrong");
  a_stby_power_off: assert property (
    mode_o == MODE_STBY && $past(mode_o) == MODE_STBY |-> reg_mode_o == REG_OFF
    && !gate_o.core_domain_pwr && !gate_o.pll_en && core_reset_o) else $error("Standby power wrong");
  a_rtc_never_stops: assert property (gate_o.rtc_run) else $error("RTC stopped");
  a_wdt_follows_cfg: assert property (
    (mode_o == MODE_DEEP || mode_o == MODE_STBY)
    |-> gate_o.independent_watchdog_run == $past(wdt_lowpwr_run_cfg_i))
    else $error("Watchdog run wrong");
  // ============================================================
  // Regulator and reset
  a_reg_normal_reset: assert property (
    $fell(rst_i) |-> reg_mode_o == REG_NORMAL) else $error("Regulator not normal after reset");
  a_lowpwr_only_stop: assert property (
    reg_mode_o == REG_LOWPWR |-> mode_o == MODE_DEEP || $past(mode_o) == MODE_DEEP)
    else $error("Low-power regulator outside clock-stop");
  a_lvr_holds_reset: assert property (
    !supply_above_lvr_i [*5] |-> core_reset_o) else $error("No reset at low supply");
  a_entry_needs_wfi: assert property (
    mode_o != MODE_RUN && $past(mode_o) == MODE_RUN |-> $past(core_wfi_i) || $past(core_wfi_i, 2))
    else $error("Low-power entry without wait");
endmodule : lpwr_monitor

bind lpwr_ctrl lpwr_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .core_wfi_i(core_wfi_i),
  .supply_above_lvr_i(supply_above_lvr_i), .wdt_lowpwr_run_cfg_i(wdt_lowpwr_run_cfg_i),
  .gate_o(gate_o), .reg_mode_o(reg_mode_o), .mode_o(mode_o), .core_reset_o(core_reset_o));

/* File: core_model.sv */
// Behavioural core that raises wait-for-interrupt on request
`timescale 1ns/1ps
module core_model
  import lpwr_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  // Request and controller state
  input  wire logic      wfi_req_i,
  input  wire pwr_mode_e mode_i,
  // Core status
  output logic           core_wfi_o
);
  // Waiting ends once the halt is seen, so a wake does not re-enter the mode at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_wfi_o <= 1'b0;
    end else if (wfi_req_i) begin
      core_wfi_o <= 1'b1;
    end else if (mode_i != MODE_RUN) begin
      core_wfi_o <= 1'b0;
    end
  end
endmodule : core_model

/* File: tb_top.sv */
// Self-checking bench for the power-mode and wake controller
`timescale 1ns/1ps
`include "lpwr_regs.svh"
module tb_top;
  import lpwr_pkg::*;
  logic        clk_i, rst_i, cyc, we, ack, wfi, wfi_req, ev, mon, low_voltage_reset, rtc, usb, wake, external_reset_pin_n;
  logic        wcfg, core_rst, mirq, wdr;
  logic [7:0]  adr;
  logic [15:0] gpio;
  logic [18:0] irq;
  logic [31:0] wdat, rdat, dat_o;
  gate_s       gate;
  reg_mode_e   rmode;
  pwr_mode_e   mode;
  int          fails, checks;

  lpwr_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .core_wfi_i(wfi), .periph_event_i(ev), .gpio_line_i(gpio), .supply_above_mon_i(mon),
    .supply_above_lvr_i(low_voltage_reset), .rtc_alarm_i(rtc), .usb_wake_i(usb), .wake_pin_i(wake),
    .external_reset_pin_n_i(external_reset_pin_n), .watchdog_reset_i(wdr), .wdt_lowpwr_run_cfg_i(wcfg),
    .gate_o(gate), .reg_mode_o(rmode), .mode_o(mode), .core_reset_o(core_rst),
    .edge_irq_o(irq), .supply_monitor_irq_o(mirq));
  core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .wfi_req_i(wfi_req), .mode_i(mode),
    .core_wfi_o(wfi));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("fails=%0d checks=%0d", fails, checks);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Classic cycle: hold everything until ack is sampled, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
    if (n >= 20) fails++;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask : rd

  task automatic wait_mode(input pwr_mode_e m);
    int n;
    n = 0;
    while (mode !== m && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    check({30'h0, mode}, {30'h0, m});
  endtask : wait_mode

  task automatic enter(input logic [31:0] ctrl, input pwr_mode_e m);
    bus(1'b1, `OFS_PWR_CTRL, ctrl);
    @(posedge clk_i);
    wfi_req <= 1'b1;
    @(posedge clk_i);
    wfi_req <= 1'b0;
    wait_mode(m);
    repeat (3) @(posedge clk_i);
  endtask : enter

  initial begin
    #200000;
    fails++;
    finish_test();
  end

  initial begin
    {rst_i, low_voltage_reset, external_reset_pin_n} = 3'b111;
    {cyc, we, wfi_req, ev, mon, rtc, usb, wake, wcfg, wdr} = '0;
    {adr, gpio, wdat, fails, checks} = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OFS_PWR_CTRL, `RESET_WORD);
    rd(8'h1C, 32'h0);
    // ============================================================
    // Rising edges on all lines; the monitor line stays out while disabled
    bus(1'b1, `OFS_EDGE_RISE, 32'h0007_FFFF);
    bus(1'b1, `OFS_EDGE_MASK, 32'h0007_FFFF);
    {gpio, rtc, usb, mon} <= '1;
    repeat (6) @(posedge clk_i);
    rd(`OFS_EDGE_PEND, 32'h0006_FFFF);
    check({13'h0, irq}, 32'h0006_FFFF);
    bus(1'b1, `OFS_EDGE_PEND, 32'h0007_FFFF);
    rd(`OFS_EDGE_PEND, 32'h0);
    // Falling-only select on line 5, masked out
    bus(1'b1, `OFS_EDGE_RISE, 32'h0);
    bus(1'b1, `OFS_EDGE_FALL, 32'h0000_0020);
    bus(1'b1, `OFS_EDGE_MASK, 32'h0007_FFDF);
    {gpio, rtc, usb} <= '0;
    repeat (6) @(posedge clk_i);
    rd(`OFS_EDGE_PEND, 32'h0000_0020);
    check({13'h0, irq}, 32'h0);
    bus(1'b1, `OFS_EDGE_PEND, 32'h0000_0020);
    // ============================================================
    // Supply monitor on falling crossing, then cleared
    bus(1'b1, `OFS_MON_CTRL, 32'h0000_0003);
    mon <= 1'b0;
    repeat (6) @(posedge clk_i);
    check({31'h0, mirq}, 32'h1);
    rd(`OFS_PWR_STAT, 32'h0000_0014);
    rd(`OFS_MON_CTRL, 32'h0000_0103);
    bus(1'b1, `OFS_MON_CTRL, 32'h0000_0103);
    repeat (2) @(posedge clk_i);
    check({31'h0, mirq}, 32'h0);
    // ============================================================
    // Sleep: no entry without wait, wake on peripheral event
    bus(1'b1, `OFS_EDGE_MASK, 32'h0);
    bus(1'b1, `OFS_PWR_CTRL, 32'h1);
    repeat (4) @(posedge clk_i);
    check({30'h0, mode}, {30'h0, MODE_RUN});
    enter(32'h1, MODE_SLEEP);
    check({30'h0, gate.core_clk_en, gate.periph_clk_en}, 32'h1);
    ev <= 1'b1;
    wait_mode(MODE_RUN);
    ev <= 1'b0;
    // Clock-stop with low-power regulator, woken by pin line 2
    bus(1'b1, `OFS_EDGE_RISE, 32'h4);
    bus(1'b1, `OFS_EDGE_MASK, 32'h4);
    enter(32'h6, MODE_DEEP);
    check({24'h0, gate}, 32'h06);
    check({30'h0, rmode}, {30'h0, REG_LOWPWR});
    gpio <= 16'h0004;
    wait_mode(MODE_RUN);
    rd(`OFS_PWR_CTRL, 32'h6);
    bus(1'b1, `OFS_EDGE_PEND, 32'h4);
    // ============================================================
    // Standby exits by wake pin and by reset pin; configuration is lost
    wcfg <= 1'b1;
    enter(32'h3, MODE_STBY);
    check({rmode, gate.core_domain_pwr, gate.rtc_run, gate.independent_watchdog_run, core_rst},
          {REG_OFF, 4'b0111});
    wake <= 1'b1;
    wait_mode(MODE_RUN);
    wake <= 1'b0;
    rd(`OFS_EDGE_RISE, 32'h0);
    enter(32'h3, MODE_STBY);
    external_reset_pin_n <= 1'b0;
    wait_mode(MODE_RUN);
    external_reset_pin_n <= 1'b1;
    // Standby exits by watchdog reset and by RTC alarm
    enter(32'h3, MODE_STBY);
    wdr <= 1'b1;
    wait_mode(MODE_RUN);
    wdr <= 1'b0;
    enter(32'h3, MODE_STBY);
    rtc <= 1'b1;
    wait_mode(MODE_RUN);
    rtc <= 1'b0;
    // Low supply holds the core in reset
    low_voltage_reset <= 1'b0;
    repeat (8) @(posedge clk_i);
    check({31'h0, core_rst}, 32'h1);
    low_voltage_reset <= 1'b1;
    repeat (8) @(posedge clk_i);
    check({31'h0, core_rst}, 32'h0);
    check({30'h0, rmode}, {30'h0, REG_NORMAL});
    finish_test();
  end
endmodule : tb_top
